//--- prog_port_defs.svh
// Constants for the serial and test-access programming port.
`ifndef PROG_PORT_DEFS_SVH
`define PROG_PORT_DEFS_SVH
`define OP_READ_PROG 8'h20
`define OP_LOAD_PAGE 8'h40
`define OP_WRITE_PAGE 8'h4C
`define OP_READ_EE 8'hA0
`define OP_WRITE_EE 8'hC0
`define OP_WRITE_CFG 8'hAC
`define OP_READ_LOCK 8'h58
`define OP_READ_FUSE 8'h50
`define OP_READ_ID 8'h30
`define OP_READ_CAL 8'h38
`define B2_FUSE_LOW 8'hA0
`define B2_FUSE_HIGH 8'hA8
`define B2_FUSE_EXT 8'hA4
`define B2_ZERO 8'h00
`define B2_EIGHT 8'h08
`define H_BIT 3
`define IR_RESET 4'hC
`define IR_ENABLE 4'h4
`define IR_COMMAND 4'h5
`define IR_PAGELOAD 4'h6
`define IR_BYPASS 4'hF
`define ENABLE_KEY 16'hA370
`define RST_LOCK 8'hFF
`define RST_FUSE 8'hFF
`define RST_FUSE_EXT 8'hFF
`define EXT_FUSE_MASK 8'h03
`define LOCK_MASK 8'h3F
`endif

//--- prog_port_pkg.sv
// Types shared by the programming port.
package prog_port_pkg;
    typedef enum logic [3:0] {
        TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
        TS_SHIFT_DR = 4'h4, TS_EXIT1_DR = 4'h5, TS_PAUSE_DR = 4'h6, TS_EXIT2_DR = 4'h7,
        TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SHIFT_IR = 4'hB,
        TS_EXIT1_IR = 4'hC, TS_PAUSE_IR = 4'hD, TS_EXIT2_IR = 4'hE, TS_UPD_IR = 4'hF
    } tap_state_t;
endpackage

//--- prog_port.sv
// Serial and test-access programming front end with its page-byte FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "prog_port_defs.svh"

module prog_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Synchronous reset.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Room available.
    input wire logic [WIDTH-1:0] in_data, // Write word.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Sink accepts.
    output logic [WIDTH-1:0] out_data // Head word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg, rp_reg;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    // Extra pointer bit separates full from empty.
    assign in_ready = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
    assign out_valid = wp_reg != rp_reg;
    assign out_data = mem[rp_reg[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (do_wr) mem[wp_reg[AW-1:0]] <= in_data;
    end
    // Pointers advance on accepted transfers only.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (do_wr) wp_reg <= wp_reg + 1'b1;
            if (do_rd) rp_reg <= rp_reg + 1'b1;
        end
    end
endmodule

module prog_port #(
    parameter int PAGE_ADDR_W = 9,
    parameter int WORD_IN_PAGE_W = 7,
    parameter int EE_ADDR_W = 12,
    parameter logic [31:0] ID_BYTES = 32'h5A_A5_3C_C3, // Arbitrary identification values.
    parameter logic [31:0] CAL_BYTES = 32'h80_80_80_80
) (
    input wire logic sys_clk, // System clock, 50 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ser_clk, // Serial programming clock pin.
    input wire logic ser_din, // Serial data in pin.
    output logic ser_dout, // Serial data out pin.
    input wire logic ext_reset_n, // External reset pin, active low.
    input wire logic tck, // Test clock pin.
    input wire logic tms, // Test mode select pin.
    input wire logic tdi, // Test data in pin.
    output logic tdo, // Test data out.
    output logic tdo_oe, // Test data out enable.
    input wire logic tap_enable_fuse, // Low means programmed.
    input wire logic tap_disable_set, // Software sets the disable bit.
    output logic tap_disable_bit, // Disable bit state.
    output logic dev_reset, // Device held in reset.
    output logic prog_mode, // Test-port programming mode.
    output logic prog_rd, // Program memory read strobe.
    output logic [PAGE_ADDR_W+WORD_IN_PAGE_W-1:0] prog_addr, // Program word address.
    input wire logic [15:0] prog_rdata, // Program word read data.
    output logic page_wr, // Page buffer byte write.
    output logic [WORD_IN_PAGE_W:0] page_idx, // Page buffer byte index.
    output logic [7:0] page_data, // Page buffer byte.
    output logic page_commit, // Commit page buffer.
    output logic [PAGE_ADDR_W-1:0] page_addr, // Page commit address.
    output logic ee_rd, // EEPROM read strobe.
    output logic ee_wr, // EEPROM write strobe.
    output logic [EE_ADDR_W-1:0] ee_addr, // EEPROM address.
    output logic [7:0] ee_wdata, // EEPROM write data.
    input wire logic [7:0] ee_rdata, // EEPROM read data.
    output logic [7:0] lock_bits, // Lock bits, zero programmed.
    output logic [7:0] fuse_low, // Low fuses.
    output logic [7:0] fuse_high, // High fuses.
    output logic [7:0] fuse_ext, // Extended fuses.
    output logic cmd_valid, // Applied command pulse per TCK rise in Idle.
    output logic [14:0] cmd_word, // Applied command word.
    input wire logic [14:0] cmd_result // Result of previous command.
);
    import prog_port_pkg::*;

    // Pin synchronisers: two flops before any logic reads them.
    logic [1:0] sck_s, sdi_s, rstn_s, tck_s, tms_s, tdi_s;
    always_ff @(posedge sys_clk) begin
        sck_s <= {sck_s[0], ser_clk};
        sdi_s <= {sdi_s[0], ser_din};
        rstn_s <= {rstn_s[0], ext_reset_n};
        tck_s <= {tck_s[0], tck};
        tms_s <= {tms_s[0], tms};
        tdi_s <= {tdi_s[0], tdi};
    end
    logic sck_d_reg, tck_d_reg;
    always_ff @(posedge sys_clk) begin
        sck_d_reg <= sck_s[1];
        tck_d_reg <= tck_s[1];
    end
    wire sck_rise = sck_s[1] && !sck_d_reg;
    wire sck_fall = !sck_s[1] && sck_d_reg;
    wire tck_rise = tck_s[1] && !tck_d_reg;
    wire tck_fall = !tck_s[1] && tck_d_reg;

    // Serial link: sampled on rising edge, MSB first per byte as on the wire.
    logic [4:0] bit_cnt_reg;
    logic [31:0] sh_reg;
    logic [7:0] out_reg;
    wire [31:0] sh_next = {sh_reg[30:0], sdi_s[1]};
    wire word_done = sck_rise && (bit_cnt_reg == 5'h1F);
    wire third_done = sck_rise && (bit_cnt_reg == 5'h17);
    wire [7:0] b1 = sh_next[31:24];
    wire [7:0] b2 = sh_next[23:16];
    wire [7:0] b3 = sh_next[15:8];
    wire [7:0] b4 = sh_next[7:0];
    wire [7:0] p1 = sh_reg[22:15];
    wire [7:0] p2 = sh_reg[14:7];
    wire [7:0] p3 = {sh_reg[6:0], sdi_s[1]};
    wire is_rd_prog = (p1 & 8'hF7) == `OP_READ_PROG;
    wire [EE_ADDR_W-1:0] p_ee = EE_ADDR_W'({p2[3:0], p3});
    // Bytes one to three as they stand in the shifter once the third byte is complete.
    wire [7:0] q1 = sh_reg[23:16];
    wire [7:0] q2 = sh_reg[15:8];
    wire [1:0] q_sel = sh_reg[1:0];
    wire q_rd_prog = (q1 & 8'hF7) == `OP_READ_PROG;
    wire q_hi = q1[`H_BIT];
    // Fourth-byte answer, chosen at the last falling edge of byte three.
    // The memories thus get several cycles after the address strobe before their data is taken.
    wire [7:0] rd_sel =
        q_rd_prog ? (q_hi ? prog_rdata[15:8] : prog_rdata[7:0]) :
        (q1 == `OP_READ_EE) ? ee_rdata :
        (q1 == `OP_READ_LOCK && q2 == `B2_ZERO) ? lock_bits :
        (q1 == `OP_READ_FUSE && q2 == `B2_ZERO) ? fuse_low :
        (q1 == `OP_READ_FUSE && q2 == `B2_EIGHT) ? fuse_ext :
        (q1 == `OP_READ_LOCK && q2 == `B2_EIGHT) ? fuse_high :
        (q1 == `OP_READ_ID) ? ID_BYTES[8*q_sel +: 8] :
        (q1 == `OP_READ_CAL) ? CAL_BYTES[8*q_sel +: 8] : 8'h00;
    always_ff @(posedge sys_clk) begin
        if (rst || !rstn_s[1]) begin
            bit_cnt_reg <= 5'h00;
            sh_reg <= 32'h0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            sh_reg <= sh_next;
        end
    end
    // Read answer taken at the last fall of byte three, then shifted out on falling edges.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_reg <= 8'h00;
            ser_dout <= 1'b0;
        end else if (sck_fall && bit_cnt_reg == 5'h18) begin
            ser_dout <= rd_sel[7];
            out_reg <= {rd_sel[6:0], 1'b0};
        end else if (sck_fall) begin
            ser_dout <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
    wire is_load = (b1 & 8'hF7) == `OP_LOAD_PAGE;
    wire is_commit = (b1 == `OP_WRITE_PAGE);
    wire is_ee_wr = (b1 == `OP_WRITE_EE);
    wire is_lock_wr = (b1 == `OP_WRITE_CFG) && (b2[7:5] == 3'b111);
    wire is_fl_wr = (b1 == `OP_WRITE_CFG) && (b2 == `B2_FUSE_LOW);
    wire is_fh_wr = (b1 == `OP_WRITE_CFG) && (b2 == `B2_FUSE_HIGH);
    wire is_fe_wr = (b1 == `OP_WRITE_CFG) && (b2 == `B2_FUSE_EXT);

    // Test access port, stepped on each synchronised TCK rising edge while tap_ok; held in Test-Logic-Reset otherwise.
    tap_state_t ts_reg, ts_next;
    logic [3:0] ir_reg, irsh_reg;
    logic rstreg_reg;
    logic [15:0] en_sh_reg;
    logic [14:0] cmd_sh_reg;
    logic [7:0] pl_sh_reg;
    logic [2:0] pl_bit_reg;
    logic [WORD_IN_PAGE_W:0] pl_idx_reg;
    logic bypass_reg;
    wire tap_ok = !tap_enable_fuse && !tap_disable_bit;
    always_comb begin
        unique case (ts_reg)
            TS_RESET: ts_next = tms_s[1] ? TS_RESET : TS_IDLE;
            TS_IDLE: ts_next = tms_s[1] ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: ts_next = tms_s[1] ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: ts_next = tms_s[1] ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: ts_next = tms_s[1] ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: ts_next = tms_s[1] ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: ts_next = tms_s[1] ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: ts_next = tms_s[1] ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: ts_next = tms_s[1] ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: ts_next = tms_s[1] ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: ts_next = tms_s[1] ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: ts_next = tms_s[1] ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: ts_next = tms_s[1] ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: ts_next = tms_s[1] ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: ts_next = tms_s[1] ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: ts_next = tms_s[1] ? TS_SEL_DR : TS_IDLE;
        endcase
    end
    wire st = tck_rise && tap_ok;
    wire sh_dr = st && ts_reg == TS_SHIFT_DR;
    wire cap_dr = st && ts_reg == TS_CAP_DR;
    wire upd_dr = st && ts_reg == TS_UPD_DR;
    wire idle_clk = st && ts_reg == TS_IDLE;
    wire ir_rst = ir_reg == `IR_RESET;
    wire ir_en = ir_reg == `IR_ENABLE;
    wire ir_cmd = ir_reg == `IR_COMMAND;
    wire ir_pl = ir_reg == `IR_PAGELOAD;
    wire key_ok = en_sh_reg == `ENABLE_KEY;
    wire pl_byte = sh_dr && ir_pl && prog_mode && pl_bit_reg == 3'h7;
    wire [7:0] pl_byte_val = {tdi_s[1], pl_sh_reg[7:1]};
    // TAP state and instruction register; instruction shifts LSB first.
    always_ff @(posedge sys_clk) begin
        if (rst || !tap_ok) begin
            ts_reg <= TS_RESET;
            ir_reg <= `IR_BYPASS;
            irsh_reg <= 4'h0;
        end else if (tck_rise) begin
            ts_reg <= ts_next;
            if (ts_reg == TS_RESET) ir_reg <= `IR_BYPASS;
            if (ts_reg == TS_CAP_IR) irsh_reg <= 4'h1;
            if (ts_reg == TS_SHIFT_IR) irsh_reg <= {tdi_s[1], irsh_reg[3:1]};
            if (ts_reg == TS_UPD_IR) ir_reg <= irsh_reg;
        end
    end
    // Data registers; the reset bit is not cleared by controller reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rstreg_reg <= 1'b0;
            en_sh_reg <= 16'h0000;
            cmd_sh_reg <= 15'h0000;
            pl_sh_reg <= 8'h00;
            pl_bit_reg <= 3'h0;
            bypass_reg <= 1'b0;
        end else begin
            if (sh_dr && ir_rst) rstreg_reg <= tdi_s[1];
            if (sh_dr && ir_en) en_sh_reg <= {tdi_s[1], en_sh_reg[15:1]};
            if (upd_dr && ir_en && !key_ok) en_sh_reg <= 16'h0000;
            if (cap_dr && ir_cmd) cmd_sh_reg <= cmd_result;
            if (sh_dr && ir_cmd) cmd_sh_reg <= {tdi_s[1], cmd_sh_reg[14:1]};
            if (cap_dr && ir_pl) pl_bit_reg <= 3'h0;
            if (sh_dr && ir_pl) begin
                pl_sh_reg <= pl_byte_val;
                pl_bit_reg <= pl_bit_reg + 3'h1;
            end
            if (sh_dr) bypass_reg <= tdi_s[1];
        end
    end
    // Test data out changes on falling TCK, driven only while shifting.
    wire tdo_sel = ir_rst ? rstreg_reg : ir_en ? en_sh_reg[0] : ir_cmd ? cmd_sh_reg[0] :
                   ir_pl ? pl_sh_reg[0] : bypass_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= tap_ok && (ts_reg == TS_SHIFT_DR || ts_reg == TS_SHIFT_IR);
            tdo <= (ts_reg == TS_SHIFT_IR) ? irsh_reg[0] : tdo_sel;
        end
    end

    // Page bytes from both paths pass the FIFO towards the page buffer.
    logic fifo_in_valid, fifo_out_valid, fifo_in_ready;
    logic [WORD_IN_PAGE_W+8:0] fifo_in_data, fifo_out_data;
    // A serial load meeting a page-load byte in the same cycle is lost; the paths are not meant to overlap.
    wire ser_load = word_done && is_load && fifo_in_ready;
    assign fifo_in_valid = ser_load || pl_byte;
    assign fifo_in_data = pl_byte ? {pl_idx_reg, pl_byte_val} :
                          {b3[WORD_IN_PAGE_W-1:0], b1[`H_BIT], b4};
    prog_fifo #(.WIDTH(WORD_IN_PAGE_W + 9), .DEPTH(16)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // Serial command execution; unmatched encodings change nothing.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lock_bits <= `RST_LOCK;
            fuse_low <= `RST_FUSE;
            fuse_high <= `RST_FUSE;
            fuse_ext <= `RST_FUSE_EXT;
            page_commit <= 1'b0;
            page_addr <= '0;
            ee_wr <= 1'b0;
            ee_rd <= 1'b0;
            ee_addr <= '0;
            ee_wdata <= 8'h00;
            prog_rd <= 1'b0;
            prog_addr <= '0;
        end else begin
            page_commit <= word_done && is_commit;
            ee_wr <= word_done && is_ee_wr;
            ee_rd <= bit_cnt_reg == 5'h17 && sck_s[1] && !sck_d_reg && (p1 == `OP_READ_EE);
            prog_rd <= bit_cnt_reg == 5'h17 && sck_rise && is_rd_prog;
            if (word_done && is_commit) page_addr <= PAGE_ADDR_W'({b2, b3[7]});
            if (word_done && is_ee_wr) begin
                ee_addr <= EE_ADDR_W'({b2[3:0], b3});
                ee_wdata <= b4;
            end
            if (third_done && p1 == `OP_READ_EE) ee_addr <= p_ee;
            if (third_done && is_rd_prog) prog_addr <= (PAGE_ADDR_W+WORD_IN_PAGE_W)'({p2, p3});
            if (word_done && is_lock_wr) lock_bits <= (b4 | ~`LOCK_MASK);
            if (word_done && is_fl_wr) fuse_low <= b4;
            if (word_done && is_fh_wr) fuse_high <= b4;
            if (word_done && is_fe_wr) fuse_ext <= (b4 | ~`EXT_FUSE_MASK);
        end
    end

    // Drain side, disable bit, reset chain, programming mode, command apply.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_wr <= 1'b0;
            page_idx <= '0;
            page_data <= 8'h00;
            tap_disable_bit <= 1'b0;
            dev_reset <= 1'b0;
            prog_mode <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_word <= 15'h0000;
            pl_idx_reg <= '0;
        end else begin
            page_wr <= fifo_out_valid;
            if (fifo_out_valid) begin
                page_idx <= fifo_out_data[WORD_IN_PAGE_W+8:8];
                page_data <= fifo_out_data[7:0];
            end
            if (!rstn_s[1]) tap_disable_bit <= 1'b0;
            else if (tap_disable_set) tap_disable_bit <= 1'b1;
            dev_reset <= rstreg_reg || !rstn_s[1];
            if (upd_dr && ir_en) prog_mode <= key_ok;
            if (upd_dr && ir_cmd) cmd_word <= cmd_sh_reg;
            cmd_valid <= idle_clk && ir_cmd && prog_mode;
            if (cap_dr && ir_pl) pl_idx_reg <= '0;
            else if (pl_byte) pl_idx_reg <= pl_idx_reg + 1'b1;
        end
    end

    AST_RST_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
        rstreg_reg |=> dev_reset) else $error("reset chain did not hold device");
    AST_KEY_MODE: assert property (@(posedge sys_clk) disable iff (rst)
        upd_dr && ir_en |=> prog_mode == $past(key_ok)) else $error("mode not from key");
    AST_CMD_APPLY: assert property (@(posedge sys_clk) disable iff (rst)
        upd_dr && ir_cmd |=> cmd_word == $past(cmd_sh_reg)) else $error("command not applied");
    AST_IDLE_CLK: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_valid |-> $past(ts_reg) == TS_IDLE && $past(ir_cmd)) else $error("clock outside idle");
    AST_EE_WR: assert property (@(posedge sys_clk) disable iff (rst)
        ee_wr |-> $past(word_done) && $past(b1) == `OP_WRITE_EE) else $error("bad eeprom write");
    AST_COMMIT: assert property (@(posedge sys_clk) disable iff (rst)
        word_done && is_commit |=> page_commit) else $error("page commit missing");
    AST_TAP_GATE: assert property (@(posedge sys_clk) disable iff (rst)
        !tap_ok |=> ts_reg == TS_RESET) else $error("tap active while disabled");
    AST_NO_SIDE: assert property (@(posedge sys_clk) disable iff (rst)
        word_done && b1 == 8'hFF |=> $stable(lock_bits) && $stable(fuse_low) && !ee_wr)
        else $error("unknown opcode had effect");
    AST_LOCK_FMT: assert property (@(posedge sys_clk) disable iff (rst)
        lock_bits[7:6] == 2'b11) else $error("lock top bits");
    // Guards on the test port, the external reset and the forced fuse bits.
    AST_CMD_MODE: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_valid |-> $past(prog_mode)) else $error("command clock without programming mode");
    AST_DIS_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        !rstn_s[1] |=> !tap_disable_bit) else $error("disable bit survived external reset");
    AST_EXT_RST: assert property (@(posedge sys_clk) disable iff (rst)
        !rstn_s[1] |=> dev_reset) else $error("external reset did not hold device");
    AST_EXT_FUSE: assert property (@(posedge sys_clk) disable iff (rst)
        fuse_ext[7:2] == 6'h3F) else $error("extended fuse top bits");
    AST_EN_CLR: assert property (@(posedge sys_clk) disable iff (rst)
        upd_dr && ir_en && !key_ok |=> en_sh_reg == 16'h0000) else $error("enable register kept bad key");
    AST_PL_CAP: assert property (@(posedge sys_clk) disable iff (rst)
        cap_dr && ir_pl |=> pl_idx_reg == '0 && pl_bit_reg == 3'h0) else $error("page-load not restarted");
    AST_IR_RESET: assert property (@(posedge sys_clk) disable iff (rst)
        tck_rise && tap_ok && ts_reg == TS_RESET |=> ir_reg == `IR_BYPASS) else $error("instruction not reset");
endmodule
`default_nettype wire

//--- programmer_model.sv
// External programmer model that drives the serial link and the three test-access pins.
`timescale 1ns/100ps
`default_nettype none
module programmer_model (
    output logic ser_clk, // Serial clock, held still between frames.
    output logic ser_din, // Serial data to the device.
    input wire logic ser_dout, // Serial data from the device.
    output logic tck, // Test clock.
    output logic tms, // Test mode select.
    output logic tdi // Test data in.
);
    // All lines start low before the first frame.
    initial begin
        {ser_clk, ser_din, tck, tms, tdi} = 5'h00;
    end
    // Every frame carries all four bytes, each byte most significant bit first.
    // Read data is taken in the high phase, well after the device moved it at the falling edge.
    task automatic spi(input logic [31:0] w, output logic [7:0] r);
        for (int i = 31; i >= 0; i--) begin
            ser_din = w[i];
            #80 ser_clk = 1'b1;
            #40 if (i < 8) r[i] = ser_dout;
            #40 ser_clk = 1'b0;
        end
        ser_din = ~ser_din;
    endtask
    // One test clock period; only the three test pins are ever driven.
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        #80 tck = 1'b0;
    endtask
    // Scans n bits into the instruction or a data register, least significant bit first.
    // The scan always ends with one visit to Run-Test/Idle, where the controller then rests.
    task automatic scan(input logic ir, input logic [15:0] v, input int n);
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
        step(1'b1, 1'b0);
        step(1'b0, ~v[n-1]);
    endtask
endmodule
`default_nettype wire

//--- serial_and_tap_programming_port_tb.sv
// Self-checking bench for the serial and test-access programming port.
`timescale 1ns/100ps
`default_nettype none
module serial_and_tap_programming_port_tb;
    logic sys_clk = 1'b0, rst = 1'b1, ext_reset_n = 1'b1, tap_enable_fuse = 1'b0, tap_disable_set = 1'b0;
    logic ser_clk, ser_din, ser_dout, tck, tms, tdi, tdo, tdo_oe, tap_disable_bit, dev_reset, prog_mode;
    logic prog_rd, page_wr, page_commit, ee_rd, ee_wr, cmd_valid;
    logic [15:0] prog_addr, tdo_cap = 16'h0000;
    logic [7:0] page_idx, page_data, ee_wdata, lock_bits, fuse_low, fuse_high, fuse_ext, r;
    logic [8:0] page_addr;
    logic [11:0] ee_addr;
    logic [14:0] cmd_word, cmd_result = 15'h2AAA;
    // Memory stand-ins answer from the address given, so a late address shows up as wrong data.
    wire [15:0] prog_rdata = prog_addr ^ 16'hAC5B;
    wire [7:0] ee_rdata = ee_addr[7:0] ^ 8'hC3;
    int mismatches = 0, n_checks = 0, cycles = 0, n_ee = 0, n_page = 0, n_cmd = 0, n_rd = 0, n_cm = 0;

    programmer_model pm (.ser_clk, .ser_din, .ser_dout, .tck, .tms, .tdi);
    // The identification value is arbitrary; equal bytes keep the check independent of byte order.
    prog_port #(.ID_BYTES(32'h3C3C_3C3C)) dut (
        .sys_clk, .rst, .ser_clk, .ser_din, .ser_dout, .ext_reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe,
        .tap_enable_fuse, .tap_disable_set, .tap_disable_bit, .dev_reset, .prog_mode, .prog_rd, .prog_addr,
        .prog_rdata, .page_wr, .page_idx, .page_data, .page_commit, .page_addr, .ee_rd, .ee_wr, .ee_addr,
        .ee_wdata, .ee_rdata, .lock_bits, .fuse_low, .fuse_high, .fuse_ext, .cmd_valid, .cmd_word, .cmd_result
    );

    always #10 sys_clk = ~sys_clk;
    // Strobes stand one cycle, so they are counted at every edge; the cycle count cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        n_ee += int'(ee_wr === 1'b1);
        n_page += int'(page_wr === 1'b1);
        n_cmd += int'(cmd_valid === 1'b1);
        n_rd += int'(ee_rd === 1'b1) + int'(prog_rd === 1'b1);
        n_cm += int'(page_commit === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Test data out is taken as a programmer would, at each test clock rise while it is driven.
    always @(posedge tck) if (tdo_oe === 1'b1) tdo_cap <= {1'b0, tdo, tdo_cap[14:1]};

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // A frame, then time for the strobe that follows the last rising edge.
    task automatic sx(input logic [31:0] w);
        pm.spi(w, r);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_mem();
        sx(32'h2812_3400);
        check(16'(r), 16'h00BE);
        check(prog_addr, 16'h1234);
        sx(32'hA00A_5500);
        check(16'(r), 16'h0096);
        check(16'(ee_addr), 16'h0A55);
        check(16'(n_rd), 16'h0002);
        sx(32'hC00A_553C);
        check(16'(ee_wdata), 16'h003C);
        check(16'(n_ee), 16'h0001);
        $display("test mem done");
    endtask

    task automatic t_cfg();
        sx(32'hACE0_00C5);
        sx(32'h5800_0000);
        check(16'(r), 16'h00C5);
        sx(32'hACA0_0012);
        sx(32'hACA8_0034);
        sx(32'hACA4_0002);
        check({fuse_high, fuse_ext}, 16'h34FE);
        sx(32'h5000_0000);
        check(16'(r), 16'h0012);
        sx(32'h5008_0000);
        check(16'(r), 16'h00FE);
        sx(32'h5808_0000);
        check(16'(r), 16'h0034);
        sx(32'h3000_0200);
        check(16'(r), 16'h003C);
        sx(32'h3800_0100);
        check(16'(r), 16'h0080);
        // A write with an unlisted second byte and an unlisted opcode must change nothing.
        sx(32'hAC00_0000);
        sx(32'hFF00_0000);
        check({lock_bits, fuse_low}, 16'hC512);
        check(16'(n_ee), 16'h0001);
        $display("test cfg done");
    endtask

    task automatic t_page();
        n_page = 0;
        sx(32'h4000_0566);
        sx(32'h4800_0577);
        check({8'(n_page), page_idx}, 16'h020B);
        check(16'(page_data), 16'h0077);
        sx(32'h4C12_8000);
        check(16'(page_addr), 16'h0025);
        check(16'(n_cm), 16'h0001);
        $display("test page done");
    endtask

    task automatic t_tap();
        repeat (5) pm.step(1'b1, 1'b0);
        pm.step(1'b0, 1'b0);
        tap_disable_set = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 tap_disable_set = 1'b0;
        pm.scan(1'b1, 16'h0004, 4);
        pm.scan(1'b0, 16'hA370, 16);
        check(16'({tap_disable_bit, prog_mode}), 16'h0002);
        ext_reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 check(16'({tap_disable_bit, dev_reset}), 16'h0001);
        ext_reset_n = 1'b1;
        // The controller sat in Test-Logic-Reset while disabled; one low step brings it to Idle.
        pm.step(1'b0, 1'b0);
        pm.scan(1'b1, 16'h000C, 4);
        pm.scan(1'b0, 16'h0001, 1);
        check(16'(dev_reset), 16'h0001);
        pm.scan(1'b0, 16'h0000, 1);
        check(16'(dev_reset), 16'h0000);
        pm.scan(1'b1, 16'h0004, 4);
        pm.scan(1'b0, 16'hA371, 16);
        check(16'(prog_mode), 16'h0000);
        pm.scan(1'b0, 16'hA370, 16);
        check(16'(prog_mode), 16'h0001);
        pm.scan(1'b1, 16'h0005, 4);
        pm.scan(1'b0, 16'h1234, 15);
        check(tdo_cap, 16'h2AAA);
        check({1'b0, cmd_word}, 16'h1234);
        // One more test clock in Run-Test/Idle executes the applied command once.
        n_cmd = 0;
        pm.step(1'b0, 1'b0);
        check(16'(n_cmd), 16'h0001);
        pm.scan(1'b1, 16'h0006, 4);
        n_page = 0;
        // The device is alone in the chain, so the page-load chain may be used.
        pm.scan(1'b0, 16'hB2A1, 16);
        check({8'(n_page), page_data}, 16'h02B2);
        $display("test tap done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset for ten cycles, then the synchronisers settle before the first frame.
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        t_mem();
        t_cfg();
        t_page();
        t_tap();
        tally_and_finish();
    end
endmodule
`default_nettype wire
